// *** common/sensor_cmd_pkg.sv ***
// Constants and types for the sensor command line parser
package sensor_cmd_pkg;

  // Command and framing characters
  localparam logic [7:0] CHAR_SET_COMP = 8'h53;
  localparam logic [7:0] CHAR_GET_COMP = 8'h73;
  localparam logic [7:0] CHAR_MASK = 8'h4D;
  localparam logic [7:0] CHAR_POLL = 8'h51;
  localparam logic [7:0] CHAR_SP = 8'h20;
  localparam logic [7:0] CHAR_CR = 8'h0D;
  localparam logic [7:0] CHAR_LF = 8'h0A;
  localparam logic [7:0] CHAR_ZERO = 8'h30;
  localparam logic [7:0] CHAR_NINE = 8'h39;

  // Field identifiers, indexed by mask bit position
  localparam logic [7:0] ID_HUMID = 8'h48;
  localparam logic [7:0] ID_NORM_FILT = 8'h64;
  localparam logic [7:0] ID_NORM_RAW = 8'h44;
  localparam logic [7:0] ID_ZERO_PT = 8'h68;
  localparam logic [7:0] ID_INVT_RAW = 8'h56;
  localparam logic [7:0] ID_TEMP = 8'h54;
  localparam logic [7:0] ID_LIGHT_FILT = 8'h4C;
  localparam logic [7:0] ID_LIGHT_RAW = 8'h6C;
  localparam logic [7:0] ID_INVT_FILT = 8'h76;
  localparam logic [7:0] ID_GAS_FILT = 8'h5A;
  localparam logic [7:0] ID_GAS_RAW = 8'h7A;

  // Values, ranges and counts
  localparam int VAL_W = 17;
  localparam logic [16:0] COMP_RESET = 17'h02000;
  localparam logic [16:0] COMP_MAX = 17'h10000;
  localparam logic [16:0] MASK_RESET = 17'h00006;
  localparam logic [3:0] FIELD_TOP = 4'hC;
  localparam logic [2:0] LAST_DIGIT = 3'h4;
  localparam logic [2:0] ARG_DIGITS = 3'h5;

  // Register offsets and field positions
  localparam logic [7:0] REG_COMP = 8'h00;
  localparam logic [7:0] REG_MASK = 8'h04;
  localparam logic [7:0] REG_CTRL = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam int CTRL_EN_BIT = 0;
  localparam int STAT_CLR_BIT = 0;

  // Receive parser states
  typedef enum logic [2:0] {
    RX_CMD = 3'b000,
    RX_ARG = 3'b001,
    RX_NUM = 3'b010,
    RX_LF = 3'b011,
    RX_BAD = 3'b100
  } rx_state_t;

  // Response generator states
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_SCAN = 3'b001,
    TX_ID = 3'b010,
    TX_SP = 3'b011,
    TX_DIG = 3'b100,
    TX_SEP = 3'b101,
    TX_CR = 3'b110,
    TX_LF = 3'b111
  } tx_state_t;

endpackage : sensor_cmd_pkg

// *** logic/sensor_cmd_parser.sv ***
// Command line parser and output field formatter for the sensor serial port
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
// Overview of operation
// - A line of 'S', space, decimal number, CR LF sets the compensation value.
// - The compensation value resets to 8192 and only 0 to 65536 is accepted.
// - A set-compensation command is answered with 'S', space and the five-digit stored value.
// - A line of 's' CR LF is answered with 's', space, the five-digit value and CR LF.
// - The measurement line holds at most five fields, chosen by the mask.
// - Each field is an identifier character, one space and exactly five decimal digits.
// - Mask weights 4096 H, 2048 d, 1024 D, 256 h, 128 V and 64 T select the upper fields.
// - Mask weights 32 and 16 light signals, 8 v, 4 Z and 2 z select the lower fields.
// - The mask is the sum of the weights, so each set bit of weight 2 to 4096 other than 512 selects one field.
// - 'M', space, up to five digits, CR LF sets the mask, echoed as 'M' and five digits; default 6.
// - Fields go out in descending weight, separated by spaces, the line ending in CR LF.
// - A line of 'Q' CR LF returns the latest values of the selected fields, at most the five of highest weight.
// - Up to five selected fields go out together on a single line.
module sensor_cmd_parser
  import sensor_cmd_pkg::*;
#(
  parameter logic [2:0] MAX_FIELDS = 3'h5
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Received command bytes
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  output logic rx_ready,
  // Transmitted response bytes
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  // Latest measurement values, one per mask bit
  input wire logic [12:0][16:0] meas_values,
  // Settings seen by the rest of the sensor
  output logic [16:0] comp_value,
  output logic [16:0] field_mask
);

  rx_state_t rx_state_q;
  tx_state_t tx_state_q;
  logic [16:0] comp_q, mask_q, acc_q, val_q, smask_q;
  logic [12:0][16:0] snap_q;
  logic [7:0] letter_q, id_q, last_cmd_q, discard_q, tx_byte;
  logic [2:0] ndig_q, dig_q, fields_q;
  logic [3:0] fld_q;
  logic has_arg_q, poll_q, en_q, rx_ready_q, tx_valid_q;
  logic [7:0] tx_data_q;
  logic [31:0] prdata_q, rdata;
  logic pready_q, pslverr_q, hit, apb_acc, wr_fire;
  logic rx_take, is_digit, commit, cmd_ok, exec, bad, slot_free, go_field, scan_end;
  logic [16:0] acc_next;

  // Identifier for a mask bit; zero where no field exists
  function automatic logic [7:0] field_id(input logic [3:0] b);
    unique case (b)
      4'hC: field_id = ID_HUMID;
      4'hB: field_id = ID_NORM_FILT;
      4'hA: field_id = ID_NORM_RAW;
      4'h8: field_id = ID_ZERO_PT;
      4'h7: field_id = ID_INVT_RAW;
      4'h6: field_id = ID_TEMP;
      4'h5: field_id = ID_LIGHT_FILT;
      4'h4: field_id = ID_LIGHT_RAW;
      4'h3: field_id = ID_INVT_FILT;
      4'h2: field_id = ID_GAS_FILT;
      4'h1: field_id = ID_GAS_RAW;
      default: field_id = 8'h00;
    endcase
  endfunction : field_id

  // ASCII decimal digit, position 0 being the most significant of five
  function automatic logic [7:0] dec_digit(input logic [16:0] v, input logic [2:0] i);
    logic [16:0] q;
    q = 17'h00000;
    unique case (i)
      3'h0: q = v / 17'd10000;
      3'h1: q = v / 17'd1000;
      3'h2: q = v / 17'd100;
      3'h3: q = v / 17'd10;
      default: q = v;
    endcase
    dec_digit = CHAR_ZERO + {4'h0, 4'(q % 17'd10)};
  endfunction : dec_digit

  // APB decode; writes land on the completing edge
  assign apb_acc = psel & penable & ~pready_q;
  assign wr_fire = psel & penable & pready_q & pwrite;
  assign hit = (paddr == REG_COMP) | (paddr == REG_MASK) | (paddr == REG_CTRL) | (paddr == REG_STATUS);

  // Read mux
  always_comb
  begin
    rdata = 32'h00000000;
    unique case (paddr)
      REG_COMP: rdata = {15'h0000, comp_q};
      REG_MASK: rdata = {15'h0000, mask_q};
      REG_CTRL: rdata = {31'h00000000, en_q};
      REG_STATUS: rdata = {15'h0000, discard_q, last_cmd_q, (tx_state_q != TX_IDLE)};
      default: rdata = 32'h00000000;
    endcase
  end

  // APB answer after one wait state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end
    else
    begin
      pready_q <= apb_acc;
      pslverr_q <= apb_acc & ~hit;
      prdata_q <= (apb_acc & ~pwrite) ? rdata : 32'h00000000;
    end
  end

  // Parser enable
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      en_q <= 1'b1;
    else if (wr_fire && paddr == REG_CTRL)
      en_q <= pwdata[CTRL_EN_BIT];
  end

  // Receive byte classification
  assign rx_take = rx_valid & rx_ready_q;
  assign is_digit = (rx_data >= CHAR_ZERO) && (rx_data <= CHAR_NINE);
  assign acc_next = 17'(acc_q * 17'd10) + {13'h0000, rx_data[3:0]};

  assign commit = rx_take && (rx_state_q == RX_LF) && (rx_data == CHAR_LF);

  always_comb
  begin
    cmd_ok = 1'b0;
    unique case (letter_q)
      CHAR_SET_COMP: cmd_ok = has_arg_q && (ndig_q != 3'h0) && (acc_q <= COMP_MAX);
      CHAR_MASK: cmd_ok = has_arg_q && (ndig_q != 3'h0);
      CHAR_GET_COMP: cmd_ok = !has_arg_q;
      CHAR_POLL: cmd_ok = !has_arg_q;
      default: cmd_ok = 1'b0;
    endcase
  end
  assign exec = commit & cmd_ok & en_q;
  assign bad = commit & ~(cmd_ok & en_q);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_state_q <= RX_CMD;
      letter_q <= 8'h00;
      acc_q <= 17'h00000;
      ndig_q <= 3'h0;
      has_arg_q <= 1'b0;
    end
    else if (rx_take)
    begin
      unique case (rx_state_q)
        RX_CMD:
        begin
          letter_q <= (rx_data == CHAR_CR) ? 8'h00 : rx_data;
          acc_q <= 17'h00000;
          ndig_q <= 3'h0;
          has_arg_q <= 1'b0;
          rx_state_q <= (rx_data == CHAR_CR) ? RX_LF : RX_ARG;
        end
        RX_ARG:
        begin
          has_arg_q <= (rx_data == CHAR_SP);
          rx_state_q <= (rx_data == CHAR_SP) ? RX_NUM : (rx_data == CHAR_CR) ? RX_LF : RX_BAD;
        end
        RX_NUM:
        begin
          if (is_digit && ndig_q != ARG_DIGITS)
          begin
            acc_q <= acc_next;
            ndig_q <= ndig_q + 3'h1;
          end
          else if (rx_data == CHAR_CR)
            rx_state_q <= RX_LF;
          else
          begin
            letter_q <= 8'h00;
            rx_state_q <= RX_BAD;
          end
        end
        RX_LF:
        begin
          if (rx_data != CHAR_LF)
            letter_q <= 8'h00;
          rx_state_q <= (rx_data == CHAR_LF) ? RX_CMD : RX_BAD;
        end
        RX_BAD:
        begin
          letter_q <= 8'h00;
          if (rx_data == CHAR_CR)
            rx_state_q <= RX_LF;
        end
        default: rx_state_q <= RX_CMD;
      endcase
    end
  end

  // Settings; a command beats an APB write in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      comp_q <= COMP_RESET;
      mask_q <= MASK_RESET;
    end
    else if (exec && letter_q == CHAR_SET_COMP)
      comp_q <= acc_q;
    else if (exec && letter_q == CHAR_MASK)
      mask_q <= acc_q;
    else if (wr_fire && paddr == REG_COMP && pwdata[16:0] <= COMP_MAX)
      comp_q <= pwdata[16:0];
    else if (wr_fire && paddr == REG_MASK)
      mask_q <= pwdata[16:0];
  end

  // Status: last command and dropped-line count; a drop in the clearing cycle leaves the count at 1
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      last_cmd_q <= 8'h00;
      discard_q <= 8'h00;
    end
    else
    begin
      if (exec)
        last_cmd_q <= letter_q;
      if (bad)
        discard_q <= (wr_fire && paddr == REG_STATUS && pwdata[STAT_CLR_BIT]) ? 8'h01 : discard_q + 8'h01;
      else if (wr_fire && paddr == REG_STATUS && pwdata[STAT_CLR_BIT])
        discard_q <= 8'h00;
    end
  end

  // Receive stalls while a response is going out
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rx_ready_q <= 1'b1;
    else if (exec)
      rx_ready_q <= 1'b0;
    else if (tx_state_q == TX_LF && slot_free)
      rx_ready_q <= 1'b1;
  end

  // Output slot and field search
  assign slot_free = ~tx_valid_q | tx_ready;
  assign scan_end = (fld_q == 4'h0) || (fields_q == MAX_FIELDS);
  assign go_field = !scan_end && smask_q[fld_q] && (field_id(fld_q) != 8'h00);

  // Byte for the current emitting state
  always_comb
  begin
    tx_byte = CHAR_SP;
    unique case (tx_state_q)
      TX_ID: tx_byte = id_q;
      TX_DIG: tx_byte = dec_digit(val_q, dig_q);
      TX_CR: tx_byte = CHAR_CR;
      TX_LF: tx_byte = CHAR_LF;
      default: tx_byte = CHAR_SP;
    endcase
  end

  // Response sequencer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_state_q <= TX_IDLE;
      id_q <= 8'h00;
      val_q <= 17'h00000;
      snap_q <= '0;
      smask_q <= 17'h00000;
      fld_q <= 4'h0;
      fields_q <= 3'h0;
      dig_q <= 3'h0;
      poll_q <= 1'b0;
    end
    else
    begin
      unique case (tx_state_q)
        TX_IDLE:
        begin
          if (exec)
          begin
            id_q <= letter_q;
            val_q <= (letter_q == CHAR_GET_COMP) ? comp_q : acc_q;
            snap_q <= meas_values;
            smask_q <= mask_q;
            fld_q <= FIELD_TOP;
            fields_q <= 3'h0;
            poll_q <= (letter_q == CHAR_POLL);
            tx_state_q <= (letter_q == CHAR_POLL) ? TX_SCAN : TX_ID;
          end
        end
        TX_SCAN:
        begin
          if (scan_end)
            tx_state_q <= TX_CR;
          else
          begin
            fld_q <= fld_q - 4'h1;
            if (go_field)
            begin
              id_q <= field_id(fld_q);
              val_q <= snap_q[fld_q];
              fields_q <= fields_q + 3'h1;
              tx_state_q <= (fields_q != 3'h0) ? TX_SEP : TX_ID;
            end
          end
        end
        TX_SEP:
          if (slot_free)
            tx_state_q <= TX_ID;
        TX_ID:
          if (slot_free)
            tx_state_q <= TX_SP;
        TX_SP:
          if (slot_free)
          begin
            dig_q <= 3'h0;
            tx_state_q <= TX_DIG;
          end
        TX_DIG:
          if (slot_free)
          begin
            dig_q <= dig_q + 3'h1;
            if (dig_q == LAST_DIGIT)
              tx_state_q <= poll_q ? TX_SCAN : TX_CR;
          end
        TX_CR:
          if (slot_free)
            tx_state_q <= TX_LF;
        TX_LF:
          if (slot_free)
            tx_state_q <= TX_IDLE;
        default: tx_state_q <= TX_IDLE;
      endcase
    end
  end

  // Byte output register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_valid_q <= 1'b0;
      tx_data_q <= 8'h00;
    end
    else if (slot_free && tx_state_q != TX_IDLE && tx_state_q != TX_SCAN)
    begin
      tx_valid_q <= 1'b1;
      tx_data_q <= tx_byte;
    end
    else if (tx_ready)
      tx_valid_q <= 1'b0;
  end

  // Outputs from flip-flops
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign rx_ready = rx_ready_q;
  assign tx_data = tx_data_q;
  assign tx_valid = tx_valid_q;
  assign comp_value = comp_q;
  assign field_mask = mask_q;

  // accepted set lands in the setting
  a_set_comp_lands: assert property (@(posedge pclk) disable iff (!presetn)
    (exec && letter_q == CHAR_SET_COMP) |=> (comp_q == $past(acc_q)))
    else $error("compensation not updated by set command");

  a_comp_in_range: assert property (@(posedge pclk) disable iff (!presetn)
    comp_q <= COMP_MAX)
    else $error("compensation out of range");

  // response opens with the command letter
  a_echo_letter: assert property (@(posedge pclk) disable iff (!presetn)
    (tx_state_q == TX_IDLE && exec && letter_q != CHAR_POLL) ##1 (tx_state_q == TX_ID && slot_free)
    |=> (tx_valid_q && tx_data_q == $past(letter_q, 2)))
    else $error("response letter wrong");

  // first digit is the ten-thousands digit
  a_first_digit: assert property (@(posedge pclk) disable iff (!presetn)
    (tx_state_q == TX_DIG && dig_q == 3'h0 && slot_free)
    |=> (tx_data_q == CHAR_ZERO + {4'h0, 4'($past(val_q) / 17'd10000)}))
    else $error("leading digit wrong");

  a_id_space: assert property (@(posedge pclk) disable iff (!presetn)
    (tx_state_q == TX_ID && slot_free) |=> (tx_state_q == TX_SP && tx_data_q == $past(id_q)))
    else $error("identifier not followed by space state");

  a_field_limit: assert property (@(posedge pclk) disable iff (!presetn)
    fields_q <= MAX_FIELDS)
    else $error("too many fields");

  a_field_selected: assert property (@(posedge pclk) disable iff (!presetn)
    (tx_state_q == TX_SCAN && go_field) |-> (smask_q[fld_q] && fld_q != 4'h9))
    else $error("unselected field emitted");

  // search walks down one weight per cycle
  a_scan_descends: assert property (@(posedge pclk) disable iff (!presetn)
    (tx_state_q == TX_SCAN && !scan_end) |=> (fld_q == $past(fld_q) - 4'h1))
    else $error("field order not descending");

  // line ends with CR then LF
  a_line_end: assert property (@(posedge pclk) disable iff (!presetn)
    (tx_state_q == TX_CR && slot_free) |=> (tx_data_q == CHAR_CR && tx_state_q == TX_LF))
    else $error("line not terminated");

  a_bad_keeps: assert property (@(posedge pclk) disable iff (!presetn)
    (bad && !wr_fire) |=> ($stable(comp_q) && $stable(mask_q) && tx_state_q == $past(tx_state_q)))
    else $error("dropped line changed state");

endmodule : sensor_cmd_parser

// *** verification/host_line_model.sv ***
// Host controller model: feeds command lines, collects response bytes
`timescale 1ns/1ns
module host_line_model
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Command bytes toward the parser
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  // Response bytes from the parser
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  // Random stalls on responses
  input wire logic slow
);
  logic [7:0] send_q[$];
  logic [7:0] got_q[$];

  // Queue one command line
  function automatic void push_line(string s);
    for (int i = 0; i < s.len(); i++)
      send_q.push_back(s[i]);
    send_q.push_back(8'h0D);
    send_q.push_back(8'h0A);
  endfunction : push_line

  // Byte feeder, each byte held until taken
  // command lines in host syntax
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
    end
    else if (!(rx_valid && !rx_ready))
    begin
      if (send_q.size() > 0)
      begin
        rx_data <= send_q.pop_front();
        rx_valid <= 1'b1;
      end
      else
      begin
        rx_valid <= 1'b0;
        rx_data <= ~rx_data; // No stale byte on idle line
      end
    end
  end

  // Response sink with optional back-pressure
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tx_ready <= 1'b0;
    else
    begin
      if (tx_valid && tx_ready)
        got_q.push_back(tx_data);
      tx_ready <= slow ? 1'($urandom_range(0, 1)) : 1'b1;
    end
  end
endmodule : host_line_model

// *** verification/sensor_output_field_command_parser_tb.sv ***
// Self-checking bench for the sensor command parser
`timescale 1ns/1ns
module sensor_output_field_command_parser_tb;
  import sensor_cmd_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slow;
  logic [7:0] paddr, rx_data, tx_data;
  logic rx_valid, rx_ready, tx_valid, tx_ready;
  logic [31:0] pwdata, prdata, rd;
  logic [12:0][16:0] meas_values;
  logic [16:0] comp_value, field_mask;
  logic er;
  int bad_count, tests_run, m;
  int vals[13];
  int masks[7] = '{4164, 0, 8190, 2, 48, 2560, 0};
  string bad[5] = '{"S 65537", "K", "S 1x", "M 123456", ""};
  logic [7:0] ids[0:12] = '{8'h00, ID_GAS_RAW, ID_GAS_FILT, ID_INVT_FILT, ID_LIGHT_RAW, ID_LIGHT_FILT,
    ID_TEMP, ID_INVT_RAW, ID_ZERO_PT, 8'h00, ID_NORM_RAW, ID_NORM_FILT, ID_HUMID};

  sensor_cmd_parser #(.MAX_FIELDS(3'h5)) u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .meas_values(meas_values), .comp_value(comp_value), .field_mask(field_mask));
  host_line_model u_host (.pclk(pclk), .presetn(presetn), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .slow(slow));

  // Clock, 4 ns period
  always #2 pclk = ~pclk;

  task complete_run;
    if (bad_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : complete_run

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
      bad_count++;
    end
  endtask : chk

  // One APB transfer, waits for pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
    begin
      chk("apb wait", 1, 0);
      complete_run;
    end
  endtask : apb

  task reg_chk(input logic [7:0] a, input int exp, input logic e);
    apb(1'b0, a, 32'h0);
    chk("prdata", exp, rd);
    chk("pslverr", e, er);
  endtask : reg_chk

  // Expected measurement line for a mask
  function automatic string q_exp(int mk);
    string s;
    int n;
    s = "";
    n = 0;
    for (int b = 12; b >= 1; b--)
      if (mk[b] && ids[b] != 8'h00 && n < 5)
      begin
        s = {s, (n > 0) ? " " : "", $sformatf("%c %05d", ids[b], vals[b])};
        n++;
      end
    return s;
  endfunction : q_exp

  // Send a line, compare the whole reply byte by byte; quiet lines expect no reply
  task run_line(input string cmd, input string exp, input bit quiet = 1'b0);
    int n;
    u_host.got_q.delete();
    u_host.push_line(cmd);
    n = 0;
    if (quiet)
      repeat (40) @(posedge pclk);
    while (!quiet && u_host.got_q.size() < exp.len() + 2 && n < 3000)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 3000)
    begin
      chk("reply wait", 1, 0);
      complete_run;
    end
    chk("reply length", quiet ? 0 : exp.len() + 2, u_host.got_q.size());
    for (int i = 0; i < u_host.got_q.size(); i++)
      chk("reply byte", (i < exp.len()) ? exp[i] : (i == exp.len() ? 8'h0D : 8'h0A), u_host.got_q[i]);
  endtask : run_line

  task new_vals;
    foreach (vals[b])
    begin
      vals[b] = $urandom_range(0, 99999);
      meas_values[b] <= 17'(vals[b]);
    end
  endtask : new_vals

  initial
  begin
    void'($urandom(32'h3855));
    {pclk, presetn, psel, penable, pwrite, slow} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    meas_values = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("comp_value", 8192, comp_value);
    chk("field_mask", 6, field_mask);
    reg_chk(REG_COMP, 8192, 1'b0);
    reg_chk(8'h10, 0, 1'b1);
    new_vals();
    run_line("s", "s 08192");
    run_line("Q", q_exp(6));
    run_line("S 65536", "S 65536");
    chk("comp_value", 65536, comp_value);
    run_line("S 0", "S 00000");
    foreach (bad[i])
      run_line(bad[i], "", 1'b1);
    chk("comp_value", 0, comp_value);
    reg_chk(REG_STATUS, (5 << 9) | (32'h53 << 1), 1'b0);
    apb(1'b1, REG_STATUS, 32'h1);
    masks[6] = $urandom_range(0, 99999);
    foreach (masks[i])
    begin
      m = masks[i];
      slow <= 1'(i % 2);
      run_line($sformatf("M %0d", m), $sformatf("M %05d", m));
      chk("field_mask", m, field_mask);
      new_vals();
      run_line("Q", q_exp(m));
    end
    apb(1'b1, REG_COMP, 32'd1234);
    apb(1'b1, REG_COMP, 32'd70000);
    reg_chk(REG_COMP, 1234, 1'b0);
    run_line("s", "s 01234");
    apb(1'b1, REG_MASK, 32'd4164);
    run_line("Q", q_exp(4164));
    reg_chk(REG_STATUS, 32'h51 << 1, 1'b0);
    // Parser disabled: a good line is dropped and counted
    apb(1'b1, REG_CTRL, 32'h0);
    reg_chk(REG_CTRL, 0, 1'b0);
    run_line("s", "", 1'b1);
    reg_chk(REG_STATUS, (1 << 9) | (32'h51 << 1), 1'b0);
    apb(1'b1, REG_CTRL, 32'h1);
    run_line("s", "s 01234");
    complete_run;
  end

  // Watchdog on the whole run
  initial
  begin
    repeat (100000) @(posedge pclk);
    bad_count++;
    complete_run;
  end
endmodule : sensor_output_field_command_parser_tb
